// file: design/gpcfg_top.sv
// Pin setup register with event routing, driver types and level interrupts
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpcfg_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [11:0] pin_in,
	output logic [11:0] pin_out,
	output logic [11:0] pin_oe_n,
	input wire logic [1:0] clock_event,
	output logic [1:0] capture_event,
	output logic timer_irq_clear,
	output logic irq
);
	import gpcfg_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [31:0] setup_reg, next_setup_reg;
	logic [11:0] pin_data_bits, next_pin_data_bits;
	logic [11:0] pin_direction_bits, next_pin_direction_bits;
	logic [12:0] irq_status, next_irq_status;
	logic [12:0] irq_mask, next_irq_mask;
	logic wr_pend, next_wr_pend;
	logic [11:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic [11:0] sync1, sync2;
	logic [1:0] ev_s1, ev_s2;
	logic [11:0] pin_act, pin_qual;
	logic [2:0] pin_cnt [gpcfg_npins];
	logic [2:0] next_pin_cnt [gpcfg_npins];
	logic [1:0] clr_qual_d, next_clr_qual_d;
	logic [1:0] clr_edge;
	logic [11:0] next_pin_out, next_pin_oe_n;
	logic [1:0] next_capture_event;
	logic next_timer_irq_clear, next_irq;

	wire logic [1:0] clr_en = setup_reg[gpcfg_clr_en_lsb +: 2];
	wire logic [11:0] pin_irq_level_select = setup_reg[gpcfg_pol_lsb +: 12];
	wire logic [1:0] evt_oe = setup_reg[gpcfg_evt_oe_lsb +: 2];
	wire logic pin9_event_polarity = setup_reg[gpcfg_evt_pol9_bit];
	wire logic pin8_event_polarity = setup_reg[gpcfg_evt_pol8_bit];
	wire logic [11:0] pin_driver_type = setup_reg[gpcfg_drv_lsb +: 12];
	wire logic [1:0] evt_pol = {pin9_event_polarity, pin8_event_polarity};
	wire logic addr_ok = hsel && hready && htrans[1];
	wire logic [11:0] rd_addr = haddr[11:0];

	////////////////////////////////////////////////////////////////////////
	// Pin and event inputs come from off-chip or another domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 12'h000;
			sync2 <= 12'h000;
			ev_s1 <= 2'h0;
			ev_s2 <= 2'h0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			ev_s1 <= clock_event;
			ev_s2 <= ev_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-pin glitch filter: count cycles at the active level
	always_comb begin
		pin_act = ~(sync2 ^ pin_irq_level_select);
	end

	for (genvar i = 0; i < gpcfg_npins; i++) begin : g_filt
		always_comb begin
			if (!pin_act[i])
				next_pin_cnt[i] = 3'h0;
			else if (pin_cnt[i] < gpcfg_filt_cyc)
				next_pin_cnt[i] = pin_cnt[i] + 3'h1;
			else
				next_pin_cnt[i] = pin_cnt[i];
			pin_qual[i] = (pin_cnt[i] == gpcfg_filt_cyc);
		end
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn)
				pin_cnt[i] <= 3'h0;
			else
				pin_cnt[i] <= next_pin_cnt[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin direction: event enables force 9 and 8 to drive
	logic [11:0] is_out;
	always_comb begin
		is_out = pin_direction_bits;
		is_out[9:8] = pin_direction_bits[9:8] | evt_oe;
		next_clr_qual_d = pin_qual[9:8];
		// Edge of the qualified level, only on inputs with clear enabled
		clr_edge = pin_qual[9:8] & ~clr_qual_d & clr_en
			& ~is_out[9:8];
		next_timer_irq_clear = |clr_edge;
		next_capture_event = pin_qual[9:8] & ~is_out[9:8];
	end

	// Output stage
	logic [11:0] drv_val;
	always_comb begin
		drv_val = pin_data_bits;
		for (int k = 0; k < 2; k++) begin
			if (evt_oe[k])
				drv_val[8 + k] = ~(ev_s2[k] ^ evt_pol[k]);
		end
		next_pin_out = 12'h000;
		next_pin_oe_n = 12'hfff;
		for (int k = 0; k < gpcfg_npins; k++) begin
			if (is_out[k]) begin
				if (pin_driver_type[k]) begin
					next_pin_out[k] = drv_val[k];
					next_pin_oe_n[k] = 1'b0;
				end else begin
					// Open drain pulls low for a 0 and floats for a 1
					next_pin_oe_n[k] = drv_val[k];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register file and bus; writes land one cycle after the address phase
	logic [12:0] ev_set, w1c;
	always_comb begin
		next_wr_pend = addr_ok && hwrite;
		next_wr_addr = rd_addr;
		next_setup_reg = setup_reg;
		next_pin_data_bits = pin_data_bits;
		next_pin_direction_bits = pin_direction_bits;
		next_irq_mask = irq_mask;
		w1c = 13'h0000;
		if (wr_pend) begin
			unique case (wr_addr)
				gpcfg_off_setup:
					next_setup_reg = hwdata & gpcfg_setup_wmask;
				gpcfg_off_pins: begin
					next_pin_data_bits = hwdata[11:0];
					next_pin_direction_bits = hwdata[gpcfg_dir_lsb +: 12];
				end
				gpcfg_off_irq_status:
					w1c = hwdata[12:0];
				gpcfg_off_irq_mask:
					next_irq_mask = hwdata[12:0];
				default: ;
			endcase
		end
		// Set beats clear so an event in the clearing cycle survives
		ev_set = {next_timer_irq_clear, pin_qual};
		next_irq_status = (irq_status & ~w1c) | ev_set;
		next_irq = |(irq_status & irq_mask);
		next_hrdata = 32'h0000_0000;
		if (addr_ok && !hwrite) begin
			unique case (rd_addr)
				gpcfg_off_setup: next_hrdata = setup_reg;
				gpcfg_off_pins: next_hrdata = {4'h0, pin_direction_bits,
					4'h0, (pin_data_bits & is_out) | (sync2 & ~is_out)};
				gpcfg_off_irq_status: next_hrdata = {19'h0, irq_status};
				gpcfg_off_irq_mask: next_hrdata = {19'h0, irq_mask};
				default: next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup_reg <= gpcfg_setup_rst;
			pin_data_bits <= 12'h000;
			pin_direction_bits <= 12'h000;
			irq_status <= gpcfg_irq_rst;
			irq_mask <= gpcfg_irq_rst;
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			clr_qual_d <= 2'h0;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			pin_out <= 12'h000;
			pin_oe_n <= 12'hfff;
			capture_event <= 2'h0;
			timer_irq_clear <= 1'b0;
			irq <= 1'b0;
		end else begin
			setup_reg <= next_setup_reg;
			pin_data_bits <= next_pin_data_bits;
			pin_direction_bits <= next_pin_direction_bits;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			clr_qual_d <= next_clr_qual_d;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			capture_event <= next_capture_event;
			timer_irq_clear <= next_timer_irq_clear;
			irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_clear_needs_input: assert property (@(posedge hclk) disable iff (!hresetn)
		timer_irq_clear |-> $past(|(clr_en & ~is_out[9:8])))
		else $error("timer clear pulsed on a disabled or output pin");
	chk_clear_one_cycle: assert property (@(posedge hclk) disable iff (!hresetn)
		timer_irq_clear |=> !timer_irq_clear)
		else $error("timer clear not a single pulse");
	chk_clear_filter: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(timer_irq_clear) |-> $past(pin_cnt[8] != 3'h0 || pin_cnt[9] != 3'h0, 2))
		else $error("timer clear without sustained active level");
	chk_irq_level_held: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_act[0] && !$past(pin_act[0]))[*1] ##1 pin_act[0] ##1 pin_act[0]
		|=> irq_status[0])
		else $error("held level did not set status");
	chk_glitch_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
		(pin_cnt[0] == 3'h1 && !pin_act[0]) |=> pin_cnt[0] == 3'h0)
		else $error("short level not discarded");
	chk_pp_drives: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_out[3] && pin_driver_type[3]) |=> !pin_oe_n[3])
		else $error("push-pull output not driven");
	chk_od_float_one: assert property (@(posedge hclk) disable iff (!hresetn)
		(is_out[2] && !pin_driver_type[2] && !evt_oe[0] && drv_val[2]) |=> pin_oe_n[2])
		else $error("open drain drove a one");
	chk_evt_od_table: assert property (@(posedge hclk) disable iff (!hresetn)
		(evt_oe[0] && !pin_driver_type[8]) |=>
		pin_oe_n[8] == $past(ev_s2[0] ~^ pin8_event_polarity))
		else $error("open drain event pin state wrong");
	chk_evt_dir: assert property (@(posedge hclk) disable iff (!hresetn)
		(evt_oe[1] && pin_driver_type[9]) |=> !pin_oe_n[9])
		else $error("event pin not driven as output");
	chk_evt_pol: assert property (@(posedge hclk) disable iff (!hresetn)
		(evt_oe[1] && pin_driver_type[9]) |=>
		pin_out[9] == $past(ev_s2[1] ~^ pin9_event_polarity))
		else $error("event output polarity wrong");

	////////////////////////////////////////////////////////////////////////
	// Capture events only come from a qualified level on an input pin
	chk_capture_pin8: assert property (@(posedge hclk)
		disable iff (!hresetn)
		capture_event[0] |-> $past(pin_qual[8] && !is_out[8]))
		else $error("pin 8 capture without qualified input level");
	chk_capture_pin9: assert property (@(posedge hclk)
		disable iff (!hresetn)
		capture_event[1] |-> $past(pin_qual[9] && !is_out[9]))
		else $error("pin 9 capture without qualified input level");

	// Status bits are sticky until software writes a one to them
	chk_status_sticky: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(irq_status[3] && !(wr_pend && wr_addr == gpcfg_off_irq_status
		&& hwdata[3])) |=> irq_status[3])
		else $error("status bit lost without a clear");
	// A qualified level sets its bit even in the cycle of a clear
	chk_status_set_wins: assert property (@(posedge hclk)
		disable iff (!hresetn)
		pin_qual[3] |=> irq_status[3])
		else $error("qualified level did not set status");
	chk_irq_follows: assert property (@(posedge hclk)
		disable iff (!hresetn)
		irq == $past(|(irq_status & irq_mask)))
		else $error("interrupt line does not follow masked status");

	// Inputs never drive; pin 8 floats unless direction or event says so
	chk_input_floats: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!pin_direction_bits[4] |=> pin_oe_n[4])
		else $error("input pin driven");
	chk_pin8_plain_dir: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(!pin_direction_bits[8] && !evt_oe[0]) |=> pin_oe_n[8])
		else $error("pin 8 driven without direction or event enable");

	// The bus never stalls or errors, and read data stands one cycle
	chk_bus_okay: assert property (@(posedge hclk)
		disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("slave stalled or signalled an error");
	chk_rd_idle_zero: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!$past(addr_ok && !hwrite) |-> hrdata == 32'h0000_0000)
		else $error("read data outside a read data phase");
endmodule // gpcfg_top
`default_nettype wire

// file: design/gpcfg_pkg.sv
// Package of register map, field layout and timing constants for the pin setup block
package gpcfg_pkg;
	localparam int unsigned gpcfg_npins = 12;
	localparam logic [11:0] gpcfg_off_setup = 12'h1e0;
	localparam logic [11:0] gpcfg_off_pins = 12'h1e4;
	localparam logic [11:0] gpcfg_off_irq_status = 12'h1e8;
	localparam logic [11:0] gpcfg_off_irq_mask = 12'h1ec;
	localparam int unsigned gpcfg_clr_en_lsb = 28;
	localparam int unsigned gpcfg_pol_lsb = 16;
	localparam int unsigned gpcfg_evt_oe_lsb = 14;
	localparam int unsigned gpcfg_evt_pol9_bit = 13;
	localparam int unsigned gpcfg_evt_pol8_bit = 12;
	localparam int unsigned gpcfg_drv_lsb = 0;
	localparam int unsigned gpcfg_dir_lsb = 16;
	localparam logic [31:0] gpcfg_setup_rst = 32'h0000_3000;
	localparam logic [31:0] gpcfg_setup_wmask = 32'h3fff_ffff;
	localparam logic [31:0] gpcfg_pins_wmask = 32'h0fff_0fff;
	// Sticky sources: bits 11:0 pin levels, bit 12 timer-clear request
	localparam logic [12:0] gpcfg_irq_rst = 13'h0000;
	localparam int unsigned gpcfg_irq_tclr_bit = 12;
	localparam int unsigned gpcfg_clk_ns = 40;
	localparam int unsigned gpcfg_min_active_ns = 40;
	// Must be active longer than the figure: strictly more cycles
	localparam int unsigned gpcfg_min_active_cyc =
		gpcfg_min_active_ns / gpcfg_clk_ns + 1;
	localparam logic [2:0] gpcfg_filt_cyc = 3'(gpcfg_min_active_cyc);
endpackage

// file: testbench/gpcfg_board.sv
// Board model for the twelve pins: pull-ups and external drivers
`timescale 1ns/1ps
`default_nettype none
module gpcfg_board (
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe_n,
	input wire logic [11:0] ext_en,
	input wire logic [11:0] ext_val,
	output logic [11:0] pin_lvl
);
	// Pull-up on every line, so a floating pin never shows a stale value
	// Board drives a line only where the bench enables it in ext_en and the block floats it
	assign pin_lvl = (~pin_oe_n & pin_out) |
		(pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule // gpcfg_board
`default_nettype wire

// file: testbench/gpcfg_tb_top.sv
// Self-checking bench for the pin setup block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module gpcfg_tb_top;
	import gpcfg_pkg::*;
	logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, capt;
	logic hreadyout, hresp, timer_irq_clear, irq;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed, rd;
	logic [1:0] htrans = 2'h0, clock_event = 2'h0, capture_event;
	logic [2:0] hsize = 3'h2;
	logic [11:0] pin_out, pin_oe_n, pin_lvl, ext_en = 12'h0, ext_val = 12'h0;
	int err_count = 0, n_tests = 0, n;
	////////////////////////////////////////////////////////////////////
	gpcfg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_lvl),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .clock_event(clock_event),
		.capture_event(capture_event), .timer_irq_clear(timer_irq_clear),
		.irq(irq));
	gpcfg_board i_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// Expected {oe_n, wire level} of an event pin
	function automatic logic [1:0] evx(input logic pol, ev, pp);
		return {pp ? 1'b0 : ~(ev ^ pol), ~(ev ^ pol)};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 16);
		if (hreadyout !== 1'b1) begin
			err_count++;
			give_verdict();
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
	endtask
	// Idle cycle after a write: a read right behind it would already see the new value
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
		@(posedge hclk);
	endtask
	task automatic pulse(input int hold, output int cnt, output logic cp);
		cnt = 0;
		cp = 1'b0;
		for (int i = 0; i < 14; i++) begin
			@(posedge hclk);
			ext_val <= (i < hold) ? 12'h200 : 12'h0;
			cnt += int'(timer_irq_clear === 1'b1);
			cp |= (capture_event[1] === 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'd27;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, gpcfg_off_setup, 0, rd);
		`CHK("setup reset", gpcfg_setup_rst, rd)
		`CHK("okay resp", 1'b0, hresp)
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			wr(gpcfg_off_setup, seed);
			bus(1'b0, gpcfg_off_setup, 0, rd);
			`CHK("setup rw", seed & gpcfg_setup_wmask, rd)
		end
		wr(12'h1f0, 32'hffff_ffff);
		bus(1'b0, 12'h1f0, 0, rd);
		`CHK("unmapped", 32'h0, rd)
		for (int k = 0; k < 8; k++) begin
			wr(gpcfg_off_setup, 32'hc000 | (k[0] ? 32'h3000 : 32'h0) |
				(k[2] ? 32'h300 : 32'h0));
			clock_event <= {2{k[1]}};
			repeat (5) @(posedge hclk);
			`CHK("event pin9", evx(k[0], k[1], k[2]), {pin_oe_n[9], pin_lvl[9]})
			`CHK("event pin8", evx(k[0], k[1], k[2]), {pin_oe_n[8], pin_lvl[8]})
		end
		clock_event <= 2'h0;
		wr(gpcfg_off_setup, 32'h20);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			wr(gpcfg_off_pins, {16'h0024, 4'h0, seed[11:0]});
			repeat (2) @(posedge hclk);
			`CHK("od pin2", {2{seed[2]}}, {pin_oe_n[2], pin_lvl[2]})
			`CHK("pp pin5", {1'b0, seed[5]}, {pin_oe_n[5], pin_lvl[5]})
			`CHK("input pin9", 1'b1, pin_oe_n[9])
		end
		wr(gpcfg_off_pins, 32'h0);
		ext_en <= 12'h200;
		wr(gpcfg_off_setup, 32'h2200_0000);
		// Four cycles high keeps the pulse well past the minimum
		pulse(4, n, capt);
		`CHK("clear pulse", 1, n)
		`CHK("capture", 1'b1, capt)
		pulse(1, n, capt);
		`CHK("short pulse", 0, n)
		wr(gpcfg_off_setup, 32'h0200_0000);
		pulse(4, n, capt);
		`CHK("clear off", 0, n)
		ext_en <= 12'h008;
		ext_val <= 12'h008;
		wr(gpcfg_off_setup, 32'h0);
		repeat (4) @(posedge hclk);
		wr(gpcfg_off_irq_status, 32'h1fff);
		wr(gpcfg_off_irq_mask, 32'h0);
		// Low level held four cycles, longer than the minimum
		ext_val <= 12'h0;
		repeat (4) @(posedge hclk);
		ext_val <= 12'h008;
		repeat (8) @(posedge hclk);
		bus(1'b0, gpcfg_off_irq_status, 0, rd);
		`CHK("pin status", 32'h8, rd)
		`CHK("irq masked", 1'b0, irq)
		wr(gpcfg_off_irq_mask, 32'h8);
		repeat (2) @(posedge hclk);
		`CHK("irq raised", 1'b1, irq)
		wr(gpcfg_off_irq_status, 32'h8);
		repeat (2) @(posedge hclk);
		`CHK("irq cleared", 1'b0, irq)
		bus(1'b0, gpcfg_off_irq_status, 0, rd);
		`CHK("status cleared", 32'h0, rd)
		give_verdict();
	end
endmodule // gpcfg_tb_top
`default_nettype wire
